// file: logic/port_irq_pkg.sv
// Constants shared by the per-port interrupt status and mask block
//
// Contract
// - Ports 1 to 7 each have a read-only 8-bit status register at N01B.
// - Status bit 3 shows serial-link auto-negotiation done, port 7 only.
// - Status bit 2 summarises timestamp interrupts, integrated-PHY ports.
// - Status bit 1 summarises integrated-PHY interrupts, PHY ports only.
// - Status bit 0 set by counter-mode access-list event, all ports.
// - Access-list status clears only when software toggles mask bit 0.
// - Ports 1 to 7 each have a read/write 8-bit mask register at N01F.
// - Mask bit 3: 0 enables auto-negotiation-done interrupt, port 7 only.
// - Mask bit 2: 0 enables timestamp summary interrupt, PHY ports.
// - Mask bit 0: 0 enables access-list interrupt, resets to 0.
`default_nettype none
package port_irq_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int NPORT = 7;
    localparam int SRC_W = 4;
    localparam int REG_W = 8;
    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_STATUS_LO = 12'h01b;
    localparam logic [11:0] IDX_MASK_LO = 12'h01f;
    localparam logic [15:0] IDX_EVT_STATUS = 16'h0010;
    localparam logic [15:0] IDX_EVT_MASK = 16'h0014;
    localparam logic [3:0] PORT_FIRST = 4'h1;
    localparam logic [3:0] PORT_LAST = 4'h7;
    // Field positions
    localparam int BIT_ACL = 0;
    localparam int BIT_PHY = 1;
    localparam int BIT_PTP = 2;
    localparam int BIT_AN = 3;
    // Reset values
    localparam logic [SRC_W-1:0] STATUS_RST = 4'h0;
    localparam logic [SRC_W-1:0] MASK_RST = 4'h0;
    localparam logic [NPORT-1:0] EVT_STATUS_RST = 7'h00;
    localparam logic [NPORT-1:0] EVT_MASK_RST = 7'h00;
    // Port arrangement defaults
    localparam logic [NPORT-1:0] PHY_PORTS_DEF = 7'h1f;
    localparam int AN_PORT_DEF = 7;
endpackage
`default_nettype wire

// file: logic/sticky_bit.sv
// Sticky flag cell where a set in the clearing cycle wins
`default_nettype none
module sticky_bit (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic set,
    input wire logic clr,
    output logic q
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= 1'b0;
        end else if (set) begin
            q <= 1'b1;
        end else if (clr) begin
            q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: logic/port_irq_unit.sv
// Status and mask logic for one port
`default_nettype none
module port_irq_unit #(
    parameter bit HAS_AN = 1'b0,
    parameter bit HAS_PHY = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic an_done,
    input wire logic ptp_irq,
    input wire logic phy_irq,
    input wire logic acl_evt,
    input wire logic mask_wr,
    input wire logic [port_irq_pkg::SRC_W-1:0] mask_wdata,
    output logic [port_irq_pkg::SRC_W-1:0] status_r,
    output logic [port_irq_pkg::SRC_W-1:0] mask_r,
    output logic contrib_r
);
    import port_irq_pkg::*;

    logic acl_q;
    logic acl_toggle;
    logic [SRC_W-1:0] status_nxt;

    // Clear fires on a change of mask bit 0, not on writing a one
    assign acl_toggle = mask_wr
        && (mask_wdata[BIT_ACL] != mask_r[BIT_ACL]);

    sticky_bit u_acl (
        .pclk(pclk),
        .presetn(presetn),
        .set(acl_evt),
        .clr(acl_toggle),
        .q(acl_q)
    );

    always_comb begin
        status_nxt = STATUS_RST;
        status_nxt[BIT_AN] = an_done && HAS_AN;
        status_nxt[BIT_PTP] = ptp_irq && HAS_PHY;
        status_nxt[BIT_PHY] = phy_irq && HAS_PHY;
        status_nxt[BIT_ACL] = acl_q;
    end

    // Summary bits are levels owned by their source units
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= STATUS_RST;
        end else begin
            status_r <= status_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= MASK_RST;
        end else if (mask_wr) begin
            mask_r <= mask_wdata;
        end
    end

    // Mask bit set to 1 disables its source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            contrib_r <= 1'b0;
        end else begin
            contrib_r <= |(status_r & ~mask_r);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Sticky cell sets on the event edge, status mirrors it one edge later
    a_acl_set_wins: assert property (
        acl_evt |=> acl_q ##1 status_r[BIT_ACL])
        else $error("acl event lost");
    a_acl_toggle_clr: assert property (
        acl_toggle && !acl_evt |=> ##1 !status_r[BIT_ACL])
        else $error("acl not cleared on toggle");
    a_acl_hold: assert property (
        acl_q && !acl_toggle |=> acl_q)
        else $error("acl cleared without toggle");
    a_an_port_only: assert property (
        HAS_AN || !status_r[BIT_AN])
        else $error("auto-negotiation bit on wrong port");
    a_phy_only: assert property (
        HAS_PHY || status_r[BIT_PTP:BIT_PHY] == 2'h0)
        else $error("phy summary on mac port");
    a_mask_store: assert property (
        mask_wr |=> mask_r == $past(mask_wdata))
        else $error("mask write not stored");
    a_contrib_gate: assert property (
        ##1 contrib_r == $past(|(status_r & ~mask_r)))
        else $error("port contribution wrong");
endmodule
`default_nettype wire

// file: logic/port_irq_top.sv
// Per-port interrupt status and mask block with APB register access
//
// Local design decisions: the APB slave port and the register addresses.
`default_nettype none
module port_irq_top #(
    parameter logic [port_irq_pkg::NPORT-1:0] PHY_PORTS =
        port_irq_pkg::PHY_PORTS_DEF,
    parameter int AN_PORT = port_irq_pkg::AN_PORT_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [port_irq_pkg::ADDR_W-1:0] paddr,
    input wire logic [port_irq_pkg::DATA_W-1:0] pwdata,
    output logic [port_irq_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic an_done,
    input wire logic [port_irq_pkg::NPORT-1:0] ptp_irq,
    input wire logic [port_irq_pkg::NPORT-1:0] phy_irq,
    input wire logic [port_irq_pkg::NPORT-1:0] acl_evt,
    output logic [port_irq_pkg::NPORT-1:0] port_irq,
    output logic irq
);
    import port_irq_pkg::*;

    logic [15:0] idx;
    logic [3:0] port_sel;
    logic [2:0] port_ix;
    logic port_ok;
    logic hit_status;
    logic hit_mask;
    logic hit_evt_st;
    logic hit_evt_mk;
    logic mapped;
    logic wr_en;
    logic [SRC_W-1:0] st_arr [NPORT];
    logic [SRC_W-1:0] mk_arr [NPORT];
    logic [NPORT-1:0] contrib;
    logic [NPORT-1:0] contrib_d_r;
    logic [NPORT-1:0] evt_status;
    logic [NPORT-1:0] evt_mask_r;
    logic [DATA_W-1:0] rd_nxt;

    // Address decode; low two bits must be zero for a word access
    assign idx = paddr[ADDR_W-1:2];
    assign port_sel = idx[15:12];
    assign port_ix = 3'(port_sel - PORT_FIRST);
    assign port_ok = (port_sel >= PORT_FIRST) && (port_sel <= PORT_LAST)
        && (paddr[1:0] == 2'h0);
    assign hit_status = port_ok && (idx[11:0] == IDX_STATUS_LO);
    assign hit_mask = port_ok && (idx[11:0] == IDX_MASK_LO);
    assign hit_evt_st = (idx == IDX_EVT_STATUS) && (paddr[1:0] == 2'h0);
    assign hit_evt_mk = (idx == IDX_EVT_MASK) && (paddr[1:0] == 2'h0);
    assign mapped = hit_status || hit_mask || hit_evt_st || hit_evt_mk;
    // Writes land only on the access edge that samples pready high
    assign wr_en = psel && penable && pready && pwrite;

    genvar g;
    generate
        for (g = 0; g < NPORT; g++) begin : gen_port
            logic mwr;
            assign mwr = wr_en && hit_mask && (port_ix == 3'(g));
            port_irq_unit #(
                .HAS_AN(AN_PORT == g + 1),
                .HAS_PHY(PHY_PORTS[g])
            ) u_unit (
                .pclk(pclk),
                .presetn(presetn),
                .an_done(an_done),
                .ptp_irq(ptp_irq[g]),
                .phy_irq(phy_irq[g]),
                .acl_evt(acl_evt[g]),
                .mask_wr(mwr),
                .mask_wdata(pwdata[SRC_W-1:0]),
                .status_r(st_arr[g]),
                .mask_r(mk_arr[g]),
                .contrib_r(contrib[g])
            );
            // Rising contribution latches until written one to clear
            sticky_bit u_evt (
                .pclk(pclk),
                .presetn(presetn),
                .set(contrib[g] && !contrib_d_r[g]),
                .clr(wr_en && hit_evt_st && pwdata[g]),
                .q(evt_status[g])
            );
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            contrib_d_r <= '0;
        end else begin
            contrib_d_r <= contrib;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_irq <= '0;
        end else begin
            port_irq <= contrib;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_mask_r <= EVT_MASK_RST;
        end else if (wr_en && hit_evt_mk) begin
            evt_mask_r <= pwdata[NPORT-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evt_status & ~evt_mask_r);
        end
    end

    // Reserved bits above each register's field (4 source bits or 7 event bits) stay zero
    always_comb begin
        rd_nxt = '0;
        if (hit_status) begin
            rd_nxt[SRC_W-1:0] = st_arr[port_ix];
        end else if (hit_mask) begin
            rd_nxt[SRC_W-1:0] = mk_arr[port_ix];
        end else if (hit_evt_st) begin
            rd_nxt[NPORT-1:0] = evt_status;
        end else if (hit_evt_mk) begin
            rd_nxt[NPORT-1:0] = evt_mask_r;
        end
    end

    // Read data captured in the setup cycle, one access cycle, no waits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (psel && !penable) begin
            pready <= 1'b1;
            pslverr <= !mapped;
            prdata <= pwrite ? '0 : rd_nxt;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not one cycle after setup");
    a_apb_unmapped: assert property (psel && !penable && !mapped |=> pslverr)
        else $error("unmapped access not flagged");
    a_evt_capture: assert property ($rose(contrib[0]) |=> evt_status[0])
        else $error("port event not latched");
    a_irq_level: assert property (##1 irq == $past(|(evt_status & ~evt_mask_r)))
        else $error("interrupt level wrong");
    a_port_out: assert property (##1 port_irq == $past(contrib))
        else $error("port output not tracking");
endmodule
`default_nettype wire

// file: verif/tb_port_irq_top.sv
// Self-checking bench for the per-port interrupt status and mask block
`default_nettype none
module tb_port_irq_top;
    timeunit 1ns;
    timeprecision 1ns;
    import port_irq_pkg::*;
    localparam logic [ADDR_W-1:0] ES_A = ADDR_W'({IDX_EVT_STATUS, 2'b00});
    localparam logic [ADDR_W-1:0] EM_A = ADDR_W'({IDX_EVT_MASK, 2'b00});
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic an_done = 1'b0;
    logic [NPORT-1:0] ptp_irq = '0;
    logic [NPORT-1:0] phy_irq = '0;
    logic [NPORT-1:0] acl_evt = '0;
    logic [NPORT-1:0] port_irq;
    logic irq;
    int failures = 0;
    int samples_checked = 0;
    logic [DATA_W-1:0] rd;
    logic err;
    logic [3:0] ex;

    port_irq_top port_irq_top_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .an_done(an_done), .ptp_irq(ptp_irq),
        .phy_irq(phy_irq), .acl_evt(acl_evt), .port_irq(port_irq),
        .irq(irq));

    always #25 pclk = ~pclk;

    function automatic logic [ADDR_W-1:0] ra(input int p,
                                             input logic [11:0] lo);
        return ADDR_W'({p[3:0], lo, 2'b00});
    endfunction

    task automatic give_verdict();
        if (failures == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Called just after a rising edge; ends one edge after release
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            $display("Error pready expected 1 seen %b", pready);
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdchk(input string name, input logic [ADDR_W-1:0] a,
                         input logic [31:0] exp);
        apb(1'b0, a, '0);
        chk(name, exp, rd);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int p = 1; p <= 7; p++) begin
            rdchk("status rst", ra(p, IDX_STATUS_LO), '0);
            rdchk("mask rst", ra(p, IDX_MASK_LO), '0);
            apb(1'b1, ra(p, IDX_MASK_LO), 32'hffff_ffff);
            rdchk("mask rw", ra(p, IDX_MASK_LO), 32'h0000_000f);
        end
        apb(1'b1, ra(1, IDX_STATUS_LO), 32'h0000_00ff);
        rdchk("status ro", ra(1, IDX_STATUS_LO), '0);
        // Auto-negotiation, timestamp and PHY sources up while every port is masked
        an_done <= 1'b1;
        ptp_irq <= '1;
        phy_irq <= '1;
        cyc(4);
        chk("port_irq masked", '0, 32'(port_irq));
        for (int p = 1; p <= 7; p++) begin
            ex = {p == AN_PORT_DEF, {2{PHY_PORTS_DEF[p-1]}}, 1'b0};
            rdchk("status lvl", ra(p, IDX_STATUS_LO), 32'(ex));
        end
        rdchk("status an", ra(7, IDX_STATUS_LO), 32'h0000_0008);
        rdchk("status mac", ra(6, IDX_STATUS_LO), '0);
        apb(1'b1, ra(7, IDX_MASK_LO), 32'h0000_0007);
        cyc(4);
        chk("port_irq an", 32'h0000_0040, 32'(port_irq));
        apb(1'b1, ra(1, IDX_MASK_LO), 32'h0000_000b);
        cyc(4);
        chk("port_irq ptp", 32'h0000_0041, 32'(port_irq));
        apb(1'b1, ra(2, IDX_MASK_LO), 32'h0000_000d);
        cyc(4);
        chk("port_irq phy", 32'h0000_0043, 32'(port_irq));
        rdchk("evt status", ES_A, 32'h0000_0043);
        chk("irq on", 32'h1, 32'(irq));
        apb(1'b1, ES_A, 32'h0000_007f);
        rdchk("evt clear", ES_A, '0);
        // Masked event still latches but must not drive irq
        apb(1'b1, EM_A, 32'h0000_007f);
        phy_irq <= '0;
        cyc(4);
        phy_irq <= '1;
        cyc(5);
        rdchk("evt masked", ES_A, 32'h0000_0002);
        chk("irq masked", '0, 32'(irq));
        apb(1'b1, EM_A, '0);
        cyc(2);
        chk("irq unmask", 32'h1, 32'(irq));
        apb(1'b1, ES_A, 32'h0000_007f);
        apb(1'b0, ra(0, 12'h123), '0);
        chk("slverr", 32'h1, 32'(err));
        chk("unmapped rd", '0, rd);
        // Misaligned word access is refused and must not write
        apb(1'b1, ra(1, IDX_MASK_LO) | 18'h1, '0);
        chk("misaligned slverr", 32'h1, 32'(err));
        rdchk("mask misaligned", ra(1, IDX_MASK_LO), 32'h0000_000b);
        an_done <= 1'b0;
        ptp_irq <= '0;
        phy_irq <= '0;
        // Access-list event on port 3, mask bit 0 cleared
        apb(1'b1, ra(3, IDX_MASK_LO), 32'h0000_000e);
        acl_evt[2] <= 1'b1;
        @(posedge pclk);
        acl_evt[2] <= 1'b0;
        cyc(4);
        chk("port_irq acl", 32'h0000_0004, 32'(port_irq));
        rdchk("acl set", ra(3, IDX_STATUS_LO), 32'h1);
        chk("irq acl", 32'h1, 32'(irq));
        apb(1'b1, ra(3, IDX_MASK_LO), 32'h0000_000e);
        rdchk("acl same wr", ra(3, IDX_STATUS_LO), 32'h1);
        apb(1'b1, ra(3, IDX_MASK_LO), 32'h0000_000f);
        rdchk("acl toggle", ra(3, IDX_STATUS_LO), '0);
        cyc(3);
        chk("port_irq idle", '0, 32'(port_irq));
        // Mid-run reset returns the mask to all sources enabled
        presetn <= 1'b0;
        cyc(2);
        chk("irq rst", '0, 32'(irq));
        presetn <= 1'b1;
        cyc(1);
        rdchk("mask rst2", ra(3, IDX_MASK_LO), '0);
        give_verdict();
    end
endmodule
`default_nettype wire
